// >>> design/black_clamp_pkg.sv
/*
 * Constants for the black clamp and output base block: register
 * offsets, field positions, reset values and stream widths.
 * Assumes a 32-bit Wishbone slave with byte addressing.
 */
package black_clamp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_OUT_ADDR = 8'h00;
    localparam logic [7:0] OFS_CLAMP = 8'h04;
    localparam logic [7:0] OFS_DC = 8'h08;
    localparam logic [7:0] OFS_COLOR = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Reset values
    localparam logic [31:0] RST_OUT_ADDR = 32'h00000000;
    localparam logic [31:0] RST_CLAMP = 32'h00000000;
    localparam logic [31:0] RST_DC = 32'h00000000;
    localparam logic [31:0] RST_COLOR = 32'h00000000;
    localparam logic [31:0] RST_CTRL = 32'h00000000;
    // Writable bit masks
    localparam logic [31:0] MASK_OUT_ADDR = 32'hFFFFFFE0;
    localparam logic [31:0] MASK_CLAMP = 32'hFFFFFC1F;
    localparam logic [31:0] MASK_DC = 32'h00003FFF;
    localparam logic [31:0] MASK_CTRL = 32'h00000007;
    // Clamp settings fields
    localparam int CL_EN_BIT = 31;
    localparam int CL_LEN_LSB = 28;
    localparam int CL_LN_LSB = 25;
    localparam int CL_ST_LSB = 10;
    localparam int CL_GAIN_LSB = 0;
    localparam int GAIN_FRAC = 4;
    // Control fields
    localparam int CT_FMT_LSB = 0;
    localparam int CT_BT656_BIT = 2;
    localparam logic [1:0] FMT_YUV8 = 2'h2;
    // Largest valid sample code (16 pixels or lines)
    localparam logic [2:0] CODE_MAX = 3'h4;
    // Stream
    localparam int PIX_W = 14;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_MARGIN = 4;
    localparam int SUM_W = 22;
    localparam int CNT_W = 16;
    localparam logic [PIX_W-1:0] PIX_MAX = 14'h3FFF;
endpackage

// >>> design/black_clamp_top.sv
/*
 * Optical-black clamp, DC subtract, colour pattern tagging and the
 * output start address, with a Wishbone slave and an output FIFO.
 * Assumes pixel and sync inputs synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module pix_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [$clog2(D):0] count_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // Honest full and empty straight from the count
    always_comb begin
        in_ready_o = (cnt_reg != D[AW:0]);
        out_valid_o = (cnt_reg != '0);
        out_data_o = mem[rp_reg];
        count_o = cnt_reg;
        push = in_valid_i & in_ready_o;
        pop = out_valid_o & out_ready_i;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_reg] <= in_data_i;
        end
    end
endmodule

module black_clamp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pix_valid_i,
    input wire logic [13:0] pix_data_i,
    input wire logic horizontal_sync_i,
    input wire logic vertical_sync_i,
    output logic pix_ready_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [13:0] out_data_o,
    output logic [1:0] out_color_o,
    output logic [31:0] output_start_address_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COLLECT = 3'b010,
        ST_HOLD = 3'b100
    } avg_state_t;

    localparam int PW = black_clamp_pkg::PIX_W;
    localparam int CW = black_clamp_pkg::CNT_W;
    localparam int SW = black_clamp_pkg::SUM_W;

    // Reserved codes behave as the largest valid one
    function automatic logic [2:0] code_clip(input logic [2:0] c);
        code_clip = (c > black_clamp_pkg::CODE_MAX) ? black_clamp_pkg::CODE_MAX : c;
    endfunction

    function automatic logic [4:0] span(input logic [2:0] c);
        span = 5'h01 << code_clip(c);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                o[8*i +: 8] = n[8*i +: 8];
            end
        end
        merge = o;
    endfunction

    // Software registers
    logic [31:0] addr_reg, addr_next, clamp_reg, clamp_next;
    logic [31:0] dc_reg, dc_next, color_reg, color_next, ctrl_reg, ctrl_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    // Frame-latched copies
    logic [31:0] act_addr_reg, act_addr_next;
    logic act_en_reg, act_en_next;
    logic [2:0] act_len_reg, act_len_next, act_ln_reg, act_ln_next;
    logic [14:0] act_st_reg, act_st_next;
    logic [4:0] act_gain_reg, act_gain_next;
    logic [PW-1:0] act_dc_reg, act_dc_next;
    // Stream state
    logic vs_d_reg, hs_d_reg, vs_rise, hs_rise;
    logic [CW-1:0] pix_cnt_reg, pix_cnt_next, line_cnt_reg, line_cnt_next;
    logic [SW-1:0] sum_reg, sum_next;
    logic [PW-1:0] black_reg, black_next;
    avg_state_t state_reg, state_next;
    logic st_valid_reg, st_valid_next;
    logic [PW+1:0] st_reg, st_next;
    logic rdy_reg, rdy_next;
    logic ov_reg, ov_next;
    logic [PW+1:0] od_reg, od_next;
    // Combinational helpers
    logic take, hit, no_clip, last_line;
    logic [PW-1:0] sub, res, avg;
    logic [PW:0] diff;
    logic [18:0] prod;
    logic [31:0] gain_ref;
    logic [CW-1:0] rel;
    logic [1:0] color;
    logic [3:0] sh;
    logic f_ready, f_ovalid, f_pop;
    logic [PW+1:0] f_odata;
    logic [$clog2(black_clamp_pkg::FIFO_DEPTH):0] f_count;
    logic wr, rd;

    // Bus slave: ack one cycle after the strobe; a write lands on the ack edge
    always_comb begin
        wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
        rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        addr_next = addr_reg;
        clamp_next = clamp_reg;
        dc_next = dc_reg;
        color_next = color_reg;
        ctrl_next = ctrl_reg;
        dat_next = 32'h00000000;
        if (wr) begin
            case (wb_adr_i)
                black_clamp_pkg::OFS_OUT_ADDR: addr_next = merge(addr_reg, wb_dat_i, wb_sel_i)
                    & black_clamp_pkg::MASK_OUT_ADDR;
                black_clamp_pkg::OFS_CLAMP: clamp_next = merge(clamp_reg, wb_dat_i, wb_sel_i)
                    & black_clamp_pkg::MASK_CLAMP;
                black_clamp_pkg::OFS_DC: dc_next = merge(dc_reg, wb_dat_i, wb_sel_i)
                    & black_clamp_pkg::MASK_DC;
                black_clamp_pkg::OFS_COLOR: color_next = merge(color_reg, wb_dat_i, wb_sel_i);
                black_clamp_pkg::OFS_CTRL: ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i)
                    & black_clamp_pkg::MASK_CTRL;
                default: ;
            endcase
        end
        // Unmapped reads return zero and still get an ack
        if (rd) begin
            case (wb_adr_i)
                black_clamp_pkg::OFS_OUT_ADDR: dat_next = addr_reg;
                black_clamp_pkg::OFS_CLAMP: dat_next = clamp_reg;
                black_clamp_pkg::OFS_DC: dat_next = dc_reg;
                black_clamp_pkg::OFS_COLOR: dat_next = color_reg;
                black_clamp_pkg::OFS_CTRL: dat_next = ctrl_reg;
                black_clamp_pkg::OFS_STATUS: dat_next = {14'h0000, state_reg == ST_COLLECT,
                    act_en_reg, 2'h0, black_reg};
                default: dat_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= black_clamp_pkg::RST_OUT_ADDR;
            clamp_reg <= black_clamp_pkg::RST_CLAMP;
            dc_reg <= black_clamp_pkg::RST_DC;
            color_reg <= black_clamp_pkg::RST_COLOR;
            ctrl_reg <= black_clamp_pkg::RST_CTRL;
            dat_reg <= 32'h00000000;
            ack_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            clamp_reg <= clamp_next;
            dc_reg <= dc_next;
            color_reg <= color_next;
            ctrl_reg <= ctrl_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
        end
    end

    // Address, clamp and DC settings apply only from a vertical sync edge; control and colour act at once
    always_comb begin
        vs_rise = vertical_sync_i & ~vs_d_reg;
        hs_rise = horizontal_sync_i & ~hs_d_reg;
        act_addr_next = vs_rise ? addr_reg : act_addr_reg;
        act_en_next = vs_rise ? clamp_reg[black_clamp_pkg::CL_EN_BIT] : act_en_reg;
        act_len_next = vs_rise ? clamp_reg[black_clamp_pkg::CL_LEN_LSB +: 3] : act_len_reg;
        act_ln_next = vs_rise ? clamp_reg[black_clamp_pkg::CL_LN_LSB +: 3] : act_ln_reg;
        act_st_next = vs_rise ? clamp_reg[black_clamp_pkg::CL_ST_LSB +: 15] : act_st_reg;
        act_gain_next = vs_rise ? clamp_reg[black_clamp_pkg::CL_GAIN_LSB +: 5] : act_gain_reg;
        act_dc_next = vs_rise ? dc_reg[PW-1:0] : act_dc_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vs_d_reg <= 1'b0;
            hs_d_reg <= 1'b0;
            act_addr_reg <= black_clamp_pkg::RST_OUT_ADDR;
            act_en_reg <= 1'b0;
            act_len_reg <= 3'h0;
            act_ln_reg <= 3'h0;
            act_st_reg <= 15'h0000;
            act_gain_reg <= 5'h00;
            act_dc_reg <= 14'h0000;
        end else begin
            vs_d_reg <= vertical_sync_i;
            hs_d_reg <= horizontal_sync_i;
            act_addr_reg <= act_addr_next;
            act_en_reg <= act_en_next;
            act_len_reg <= act_len_next;
            act_ln_reg <= act_ln_next;
            act_st_reg <= act_st_next;
            act_gain_reg <= act_gain_next;
            act_dc_reg <= act_dc_next;
        end
    end

    // Black window, averaging and pixel correction
    always_comb begin
        take = pix_valid_i & rdy_reg;
        rel = pix_cnt_reg - {1'b0, act_st_reg};
        hit = (state_reg == ST_COLLECT) & take & (pix_cnt_reg >= {1'b0, act_st_reg})
            & (rel < {11'h000, span(act_len_reg)})
            & (line_cnt_reg != '0) & (line_cnt_reg <= {11'h000, span(act_ln_reg)});
        last_line = (line_cnt_reg == {11'h000, span(act_ln_reg)});
        sh = {1'b0, code_clip(act_len_reg)} + {1'b0, code_clip(act_ln_reg)};
        avg = PW'(sum_reg >> sh);
        prod = avg * act_gain_reg;
        gain_ref = ((32'(sum_reg) >> sh) * 32'(act_gain_reg)) >> black_clamp_pkg::GAIN_FRAC;
        sub = act_en_reg ? black_reg : act_dc_reg;
        diff = {1'b0, pix_data_i} - {1'b0, sub};
        no_clip = (ctrl_reg[black_clamp_pkg::CT_FMT_LSB +: 2] == black_clamp_pkg::FMT_YUV8)
            | ctrl_reg[black_clamp_pkg::CT_BT656_BIT];
        res = (diff[PW] & ~no_clip) ? '0 : diff[PW-1:0];
        color = color_reg[{line_cnt_reg[1:0] - 2'h1, pix_cnt_reg[1:0], 1'b0} +: 2];
        pix_cnt_next = hs_rise ? '0 : (take ? pix_cnt_reg + 1'b1 : pix_cnt_reg);
        line_cnt_next = vs_rise ? '0 : (hs_rise ? line_cnt_reg + 1'b1 : line_cnt_reg);
        sum_next = hit ? sum_reg + {8'h00, pix_data_i} : sum_reg;
        black_next = black_reg;
        state_next = state_reg;
        case (state_reg)
            ST_IDLE, ST_HOLD: begin
                if (vs_rise && act_en_next) begin
                    state_next = ST_COLLECT;
                    sum_next = '0;
                end
            end
            ST_COLLECT: begin
                if (vs_rise) begin
                    state_next = act_en_next ? ST_COLLECT : ST_IDLE;
                    sum_next = '0;
                end else if (hs_rise && last_line) begin
                    // Scaled level saturates since gain may approach two
                    black_next = prod[18] ? black_clamp_pkg::PIX_MAX
                        : prod[PW+black_clamp_pkg::GAIN_FRAC-1:black_clamp_pkg::GAIN_FRAC];
                    state_next = ST_HOLD;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        st_valid_next = take;
        st_next = take ? {color, res} : st_reg;
        // Ready leaves room for pixels already in flight
        rdy_next = f_count <= 5'(black_clamp_pkg::FIFO_DEPTH - black_clamp_pkg::FIFO_MARGIN);
        f_pop = ~ov_reg | out_ready_i;
        ov_next = f_pop ? f_ovalid : ov_reg;
        od_next = (f_pop && f_ovalid) ? f_odata : od_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pix_cnt_reg <= '0;
            line_cnt_reg <= '0;
            sum_reg <= '0;
            black_reg <= '0;
            state_reg <= ST_IDLE;
            st_valid_reg <= 1'b0;
            st_reg <= '0;
            rdy_reg <= 1'b0;
            ov_reg <= 1'b0;
            od_reg <= '0;
        end else begin
            pix_cnt_reg <= pix_cnt_next;
            line_cnt_reg <= line_cnt_next;
            sum_reg <= sum_next;
            black_reg <= black_next;
            state_reg <= state_next;
            st_valid_reg <= st_valid_next;
            st_reg <= st_next;
            rdy_reg <= rdy_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
        end
    end

    pix_fifo #(.W(PW + 2), .D(black_clamp_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(st_valid_reg),
        .in_ready_o(f_ready),
        .in_data_i(st_reg),
        .out_valid_o(f_ovalid),
        .out_ready_i(f_pop),
        .out_data_o(f_odata),
        .count_o(f_count)
    );

    // Every output straight from a flop
    always_comb begin
        wb_dat_o = dat_reg;
        wb_ack_o = ack_reg;
        pix_ready_o = rdy_reg;
        out_valid_o = ov_reg;
        out_data_o = od_reg[PW-1:0];
        out_color_o = od_reg[PW +: 2];
        output_start_address_o = act_addr_reg;
    end

    sequence s_last_line_end;
        state_reg == ST_COLLECT && hs_rise && last_line && !vs_rise;
    endsequence

    sequence s_pix_in;
        take;
    endsequence

    AST_ADDR_VSYNC: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(output_start_address_o) |-> $past(vs_rise))
        else $error("start address changed without vertical sync");
    AST_ADDR_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
        output_start_address_o[4:0] == 5'h00)
        else $error("start address not 32-byte aligned");
    AST_ADDR_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && wb_adr_i == black_clamp_pkg::OFS_OUT_ADDR |=> wb_ack_o && wb_dat_o[4:0] == 5'h00)
        else $error("address read low bits not zero");
    AST_EN_VSYNC: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(act_en_reg) |-> $past(vs_rise && clamp_reg[31] != act_en_reg))
        else $error("clamp enable changed outside vertical sync");
    AST_WIN_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        hit |-> pix_cnt_reg - {1'b0, act_st_reg} < (16'h0001 << code_clip(act_len_reg)))
        else $error("black sample past window length");
    AST_WIN_LINES: assert property (@(posedge clk_i) disable iff (rst_i)
        hit |-> line_cnt_reg >= 16'h0001 && line_cnt_reg <= (16'h0001 << code_clip(act_ln_reg)))
        else $error("black sample outside line window");
    AST_WIN_START: assert property (@(posedge clk_i) disable iff (rst_i)
        hit |-> pix_cnt_reg >= {1'b0, act_st_reg})
        else $error("black sample before start pixel");
    AST_AVG_GAIN: assert property (@(posedge clk_i) disable iff (rst_i)
        s_last_line_end ##1 (act_gain_reg == 5'h00) |-> black_reg == 14'h0000)
        else $error("zero gain did not give zero level");
    AST_AVG_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_last_line_end |=> state_reg == ST_HOLD && 32'(black_reg) == (($past(gain_ref) > 32'h00003FFF)
            ? 32'h00003FFF : $past(gain_ref)))
        else $error("averaging did not complete");
    AST_DC_SUB: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pix_in and (!act_en_reg && pix_data_i >= act_dc_reg)
            |=> st_reg[13:0] == $past(pix_data_i - act_dc_reg))
        else $error("dc level not subtracted");
    AST_NO_CLIP: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pix_in and no_clip |=> st_reg[13:0] == $past(pix_data_i - sub))
        else $error("negative result clipped in yuv mode");
    AST_CLIP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pix_in and (!no_clip && pix_data_i < sub) |=> st_reg[13:0] == 14'h0000)
        else $error("negative result not saturated");
    AST_COLOR: assert property (@(posedge clk_i) disable iff (rst_i)
        s_pix_in and (line_cnt_reg[1:0] == 2'h1 && pix_cnt_reg[1:0] == 2'h0)
            |=> st_reg[15:14] == $past(color_reg[1:0]))
        else $error("colour code mismatch");
endmodule

`default_nettype wire

// >>> test/pixel_source.sv
/*
 * Model of the sensor side: a pixel stream with horizontal and vertical
 * sync pulses, driven through its tasks by the bench, one call at a time.
 * Assumes the same clock as the block and a ready that may stall.
 */
`timescale 1ns/1ps
`default_nettype none

module pixel_source (
    input wire logic clk_i,
    input wire logic pix_ready_i,
    output logic pix_valid_o,
    output logic [13:0] pix_data_o,
    output logic horizontal_sync_o,
    output logic vertical_sync_o,
    output logic timeout_o
);
    // Idle levels from time zero
    initial begin
        pix_valid_o = 1'b0;
        pix_data_o = 14'h0000;
        horizontal_sync_o = 1'b0;
        vertical_sync_o = 1'b0;
        timeout_o = 1'b0;
    end

    // One pixel, held until taken; released data shows its inverse, not stale
    task automatic send_pix(input logic [13:0] v);
        int n;
        n = 0;
        @(posedge clk_i);
        pix_valid_o <= 1'b1;
        pix_data_o <= v;
        do begin
            @(posedge clk_i);
            n++;
        end while (pix_ready_i !== 1'b1 && n < 300);
        timeout_o <= (n >= 300);
        pix_valid_o <= 1'b0;
        pix_data_o <= ~v;
    endtask

    // Sync pulse two cycles wide, then a quiet gap before any pixel
    task automatic sync(input logic v, input logic h);
        @(posedge clk_i);
        vertical_sync_o <= v;
        horizontal_sync_o <= h;
        repeat (2) @(posedge clk_i);
        vertical_sync_o <= 1'b0;
        horizontal_sync_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// >>> test/testbench.sv
/*
 * Self-checking bench for the black clamp block: Wishbone register tasks,
 * a pixel source model and an output scoreboard fed from expected words.
 * Assumes the package offsets and a 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic out_ready_i = 1'b1;
    logic [31:0] wb_dat_o, output_start_address_o, rd;
    logic wb_ack_o, pix_ready_o, out_valid_o, pix_valid, hsync, vsync, src_to;
    logic [13:0] pix_data, out_data_o;
    logic [1:0] out_color_o;
    logic [31:0] cmap = 32'h00000000;
    logic [16:0] expq[$];
    logic [16:0] e;
    int mismatches = 0;
    int cmp_count = 0;
    int line_no = 0;
    int pix_no = 0;

    always #20 clk_i = ~clk_i;

    black_clamp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_valid_i(pix_valid), .pix_data_i(pix_data),
        .horizontal_sync_i(hsync), .vertical_sync_i(vsync), .pix_ready_o(pix_ready_o),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
        .out_color_o(out_color_o), .output_start_address_o(output_start_address_o));
    pixel_source u_src (.clk_i(clk_i), .pix_ready_i(pix_ready_o), .pix_valid_o(pix_valid),
        .pix_data_o(pix_data), .horizontal_sync_o(hsync), .vertical_sync_o(vsync), .timeout_o(src_to));

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fail($sformatf("%s got %h expected %h", msg, got, exp));
        end
    endtask

    task automatic check_pix(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail($sformatf("output word got %h expected %h", got, exp));
        end
    endtask

    // Classic single cycle; waits for ack, never assumes its latency
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            fail("bus ack missing");
            tally_and_finish();
        end
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h00000000);
        check32(rd, exp, "register read");
    endtask

    // Expected word: colour from the map, data minus level, clipped unless wrap
    task automatic pix(input logic [13:0] v, input logic [13:0] lvl, input logic wrap, input logic ign);
        logic [14:0] d;
        int li;
        d = {1'b0, v} - {1'b0, lvl};
        li = (line_no + 3) % 4;
        if (d[14] && !wrap) begin
            d = 15'h0000;
        end
        expq.push_back({ign, cmap[(li * 4 + pix_no % 4) * 2 +: 2], d[13:0]});
        pix_no++;
        u_src.send_pix(v);
    endtask

    task automatic hs();
        u_src.sync(1'b0, 1'b1);
        line_no++;
        pix_no = 0;
    endtask

    task automatic vs();
        u_src.sync(1'b1, 1'b0);
        line_no = 0;
        pix_no = 0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (expq.size() != 0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        check32(expq.size(), 0, "output words missing");
    endtask

    // Scoreboard on every accepted output word
    always @(posedge clk_i) begin
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            if (expq.size() == 0) begin
                fail("unexpected output word");
            end else begin
                e = expq.pop_front();
                if (!e[16]) begin
                    check_pix({out_color_o, out_data_o}, e[15:0]);
                end
            end
        end
        if (src_to === 1'b1) begin
            fail("pixel source stalled too long");
            tally_and_finish();
        end
    end

    task automatic t_regs();
        rdchk(black_clamp_pkg::OFS_OUT_ADDR, 32'h00000000);
        rdchk(black_clamp_pkg::OFS_CLAMP, 32'h00000000);
        rdchk(black_clamp_pkg::OFS_DC, 32'h00000000);
        rdchk(black_clamp_pkg::OFS_COLOR, 32'h00000000);
        wb(1'b1, black_clamp_pkg::OFS_OUT_ADDR, 32'h1234567F);
        rdchk(black_clamp_pkg::OFS_OUT_ADDR, 32'h12345660);
        check32(output_start_address_o, 32'h00000000, "address before sync");
        wb(1'b1, black_clamp_pkg::OFS_CLAMP, 32'hFFFFFFFF);
        rdchk(black_clamp_pkg::OFS_CLAMP, 32'hFFFFFC1F);
        wb(1'b1, black_clamp_pkg::OFS_CLAMP, 32'h00000000);
        wb(1'b1, black_clamp_pkg::OFS_DC, 32'hFFFFFFFF);
        rdchk(black_clamp_pkg::OFS_DC, 32'h00003FFF);
        rdchk(8'h20, 32'h00000000);
        vs();
        check32(output_start_address_o, 32'h12345660, "address after sync");
        $display("test regs done");
    endtask

    // DC subtract with clamp off, back-pressure into the FIFO, format modes
    task automatic t_dc();
        logic [2:0] codes[4] = '{3'h2, 3'h4, 3'h1, 3'h3};
        cmap = 32'h1BE4E4E7;
        wb(1'b1, black_clamp_pkg::OFS_COLOR, cmap);
        wb(1'b1, black_clamp_pkg::OFS_DC, 32'h00000010);
        vs();
        hs();
        out_ready_i <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            pix((i % 3 == 0) ? 14'h0005 : 14'h0100 + 14'(i), 14'h0010, 1'b0, 1'b0);
        end
        repeat (12) @(posedge clk_i);
        check32(pix_ready_o, 32'h0, "ready with fifo nearly full");
        check32(out_valid_o, 32'h1, "output held while stalled");
        out_ready_i <= 1'b1;
        drain();
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, black_clamp_pkg::OFS_CTRL, {29'h0, codes[k]});
            hs();
            for (int j = 0; j < 4; j++) begin
                pix(14'h0003 + 14'(j), 14'h0010, codes[k][1:0] == 2'h2 || codes[k][2], 1'b0);
            end
            drain();
        end
        wb(1'b1, black_clamp_pkg::OFS_CTRL, 32'h00000000);
        $display("test dc done");
    endtask

    // Two black pixels from position 2 on one line, gain 1.5
    task automatic t_clamp();
        wb(1'b1, black_clamp_pkg::OFS_CLAMP, {1'b1, 3'h1, 3'h0, 15'h0002, 5'h00, 5'h18});
        wb(1'b1, black_clamp_pkg::OFS_OUT_ADDR, 32'h0ABCD100);
        vs();
        check32(output_start_address_o, 32'h0ABCD100, "second address");
        hs();
        pix(14'h3FFF, 14'h0000, 1'b0, 1'b0);
        pix(14'h3FFF, 14'h0000, 1'b0, 1'b0);
        pix(14'h0040, 14'h0000, 1'b0, 1'b0);
        pix(14'h0060, 14'h0000, 1'b0, 1'b0);
        hs();
        pix(14'h0200, 14'h0078, 1'b0, 1'b0);
        pix(14'h0050, 14'h0078, 1'b0, 1'b0);
        drain();
        $display("test clamp done");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_dc();
        t_clamp();
        tally_and_finish();
    end

    // Global watchdog
    initial begin
        repeat (60000) @(posedge clk_i);
        fail("run timed out");
        tally_and_finish();
    end
endmodule

`default_nettype wire
